/* design/framer_cfg.svh */
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH

`define ADR_W 8
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_VOICE 8'h08
`define ADR_CHAL 8'h0c
`define ADR_LAST 8'h10

`define INFO_W 28
`define PAR_W 12
`define WORD_W 40
`define BITCNT_W 6
`define PARITY_POLY 12'h5a3
`define INFO_RST 28'h0000000

`define CTRL_SEND_VOICE 0
`define CTRL_SEND_CHAL 1
`define CTRL_LAST 2
`define ST_BUSY 0
`define ST_FULL 1
`define ST_WIDTH_ERR 2
`define ST_TYPE_ERR 3

`define CHAL_END_BIT 3
`define OHD_GLOBAL 3'h4
`define OHD_SYS1 3'h6
`define OHD_SYS2 3'h7

`define CLK_HZ 125000000
`define BIT_RATE_HZ 10000
`define BIT_CYCLES (`CLK_HZ / `BIT_RATE_HZ)
`define FIFO_DEPTH 4

`endif

/* design/framer_pkg.sv */
`include "framer_cfg.svh"

package framer_pkg;

	typedef struct packed {
		logic [1:0] message_type_field;
		logic [1:0] new_channel_tone_code;
		logic [1:0] present_channel_tone_code;
		logic [7:0] reserved_pattern_bits;
		logic [2:0] voice_power_attenuation_code;
		logic [10:0] designated_voice_link_number;
	} voice_channel_control_word_t;

	typedef struct packed {
		logic [1:0] message_type_field;
		logic [1:0] digital_colour_code;
		logic [3:0] global_command_code;
		logic [15:0] auth_random_upper_half;
		logic end_flag;
		logic [2:0] overhead_word_type;
	} first_random_challenge_word_t;

	typedef struct packed {
		logic [`INFO_W-1:0] info;
		logic [`PAR_W-1:0] parity;
	} framed_word_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01
	} tx_state_t;

endpackage

/* design/voice_and_overhead_word_framer.sv */
// Overview of operation
// R1 - Two-bit message type field heads every word.
// R2 - Voice control word carries two-bit new channel tone code.
// R3 - Voice control word carries two-bit present channel tone code.
// R4 - Software fills the eight reserved bits with the fixed pattern.
// R5 - Voice control word carries three-bit power attenuation code.
// R6 - Voice control word carries eleven-bit designated voice channel number.
// R7 - Parity is generated internally; software can never override it.
// R8 - Challenge word carries two-bit digital colour code after message type.
// R9 - Challenge word carries four-bit global action code.
// R10 - Challenge word carries upper sixteen bits of authentication random value.
// R11 - End flag high only on last word of a train.
// R12 - Overhead type is 100, 110 or 111; other codes rejected. A challenge sent before any accepted write carries reset type 000.
// R13 - Word is 28 info bits then 12 parity bits, MSB first.
// R14 - Field writes of wrong width are rejected and flagged, never truncated.

`timescale 1ns/10ps
`include "framer_cfg.svh"

module word_fifo #(
	parameter int WIDTH = `WORD_W,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push, pop;

	assign in_ready_o = (count_q != (AW+1)'(DEPTH));
	assign out_valid_o = (count_q != '0);
	assign out_data_o = mem_q[rd_ptr_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	// Explicit wrap keeps non power of two depths correct
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
		end else if (push) begin
			wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr_q + 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ptr_q <= '0;
		end else if (pop) begin
			rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr_q + 1'b1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_q <= '0;
		end else if (push & ~pop) begin
			count_q <= (AW+1)'(count_q + 1'b1);
		end else if (pop & ~push) begin
			count_q <= (AW+1)'(count_q - 1'b1);
		end
	end

endmodule

module voice_and_overhead_word_framer
	import framer_pkg::*;
#(
	parameter int BIT_CYCLES = `BIT_CYCLES,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tx_hold_i,
	output logic tx_data_o,
	output logic tx_gate_o
);

	function automatic logic [`PAR_W-1:0] calc_parity(input logic [`INFO_W-1:0] info);
		logic [`PAR_W-1:0] r;
		logic fb;
		r = '0;
		fb = 1'b0;
		for (int i = `INFO_W - 1; i >= 0; i--) begin
			fb = info[i] ^ r[`PAR_W-1];
			r = {r[`PAR_W-2:0], 1'b0};
			if (fb) begin
				r = r ^ `PARITY_POLY;
			end
		end
		return r;
	endfunction

	voice_channel_control_word_t voice_q;
	first_random_challenge_word_t chal_q;
	logic [`PAR_W-1:0] last_par_q;
	logic width_err_q, type_err_q, ack_q;
	logic [31:0] dat_q;
	logic hold_meta_q, hold_sync_q;
	tx_state_t state_q;
	logic [`WORD_W-1:0] shift_q;
	logic [`BITCNT_W-1:0] bit_cnt_q;
	logic [31:0] tick_q;
	logic gate_q;

	logic wb_req, wb_fire, wr_ctrl, wr_status, wr_voice, wr_chal, field_ok, ohd_ok;
	logic send_voice, send_chal, send_any, stall, fifo_in_valid, fifo_in_ready;
	framed_word_t fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [`WORD_W-1:0] fifo_out_data;
	logic [31:0] rdata;
	first_random_challenge_word_t chal_wr;

	assign wb_req = wb_cyc_i & wb_stb_i;
	assign wb_fire = wb_req & ack_q;
	assign wr_ctrl = wb_we_i & (wb_adr_i == `ADR_CTRL);
	assign wr_status = wb_we_i & (wb_adr_i == `ADR_STATUS);
	assign wr_voice = wb_we_i & (wb_adr_i == `ADR_VOICE);
	assign wr_chal = wb_we_i & (wb_adr_i == `ADR_CHAL);
	// Field width check
	// R14 all bytes and zero pad
	assign field_ok = (wb_sel_i == 4'hf) && (wb_dat_i[31:`INFO_W] == '0);
	assign chal_wr = wb_dat_i[`INFO_W-1:0];
	// R12 legal type codes
	assign ohd_ok = (chal_wr.overhead_word_type == `OHD_GLOBAL) ||
		(chal_wr.overhead_word_type == `OHD_SYS1) ||
		(chal_wr.overhead_word_type == `OHD_SYS2);
	assign send_voice = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_SEND_VOICE];
	assign send_chal = wr_ctrl & wb_sel_i[0] & wb_dat_i[`CTRL_SEND_CHAL];
	assign send_any = send_voice | send_chal;
	// Holding ack is the back-pressure: a send waits until the queue has room
	assign stall = send_any & ~fifo_in_ready;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req & ~ack_q & ~stall;
		end
	end

	always_comb begin
		rdata = 32'h00000000;
		case (wb_adr_i)
			`ADR_STATUS: begin
				rdata[`ST_BUSY] = (state_q != TX_IDLE) | fifo_out_valid;
				rdata[`ST_FULL] = ~fifo_in_ready;
				rdata[`ST_WIDTH_ERR] = width_err_q;
				rdata[`ST_TYPE_ERR] = type_err_q;
			end
			`ADR_VOICE: rdata = {4'h0, voice_q};
			`ADR_CHAL: rdata = {4'h0, chal_q};
			`ADR_LAST: rdata = {20'h00000, last_par_q};
			default: rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h00000000;
		end else if (wb_req & ~ack_q) begin
			dat_q <= rdata;
		end
	end

	// R4 reserved bits stored as given
	// R2 R3 R5 R6 voice fields latched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			voice_q <= `INFO_RST;
		end else if (wb_fire & wr_voice & field_ok) begin
			voice_q <= wb_dat_i[`INFO_W-1:0];
		end
	end

	// R8 R9 R10 challenge fields latched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chal_q <= `INFO_RST;
		end else if (wb_fire & wr_chal & field_ok & ohd_ok) begin
			chal_q <= chal_wr;
		end
	end

	// R14 sticky width error
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			width_err_q <= 1'b0;
		end else begin
			width_err_q <= (width_err_q &
				~(wb_fire & wr_status & wb_sel_i[0] & wb_dat_i[`ST_WIDTH_ERR])) |
				(wb_fire & (wr_voice | wr_chal) & ~field_ok);
		end
	end

	// R12 sticky type error
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			type_err_q <= 1'b0;
		end else begin
			type_err_q <= (type_err_q &
				~(wb_fire & wr_status & wb_sel_i[0] & wb_dat_i[`ST_TYPE_ERR])) |
				(wb_fire & wr_chal & field_ok & ~ohd_ok) |
				(wb_fire & send_voice & send_chal);
		end
	end

	// R1 R13 info bits then parity
	// R11 end flag from the send command
	// R7 parity always generated
	always_comb begin
		fifo_in_data.info = voice_q;
		if (send_chal) begin
			fifo_in_data.info = {chal_q[`INFO_W-1:`CHAL_END_BIT+1],
				wb_dat_i[`CTRL_LAST], chal_q[`CHAL_END_BIT-1:0]};
		end
		fifo_in_data.parity = calc_parity(fifo_in_data.info);
	end

	// Asking for both word types at once is refused as a type error
	assign fifo_in_valid = wb_fire & (send_voice ^ send_chal);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last_par_q <= '0;
		end else if (fifo_in_valid) begin
			last_par_q <= fifo_in_data.parity;
		end
	end

	word_fifo #(
		.WIDTH(`WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_meta_q <= 1'b0;
			hold_sync_q <= 1'b0;
		end else begin
			hold_meta_q <= tx_hold_i;
			hold_sync_q <= hold_meta_q;
		end
	end

	// Hold only stops the next word; a word on air always completes
	assign fifo_out_ready = (state_q == TX_IDLE) & ~hold_sync_q;

	// R13 msb first shifting
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= TX_IDLE;
			shift_q <= '0;
			bit_cnt_q <= '0;
			tick_q <= 32'h00000000;
			gate_q <= 1'b0;
		end else begin
			case (state_q)
				TX_IDLE: begin
					if (fifo_out_valid & fifo_out_ready) begin
						state_q <= TX_SHIFT;
						shift_q <= fifo_out_data;
						bit_cnt_q <= '0;
						tick_q <= 32'h00000000;
						gate_q <= 1'b1;
					end
				end
				TX_SHIFT: begin
					if (tick_q == 32'(BIT_CYCLES - 1)) begin
						tick_q <= 32'h00000000;
						if (bit_cnt_q == `BITCNT_W'(`WORD_W - 1)) begin
							state_q <= TX_IDLE;
							gate_q <= 1'b0;
							shift_q <= '0;
						end else begin
							bit_cnt_q <= `BITCNT_W'(bit_cnt_q + 1'b1);
							shift_q <= {shift_q[`WORD_W-2:0], 1'b0};
						end
					end else begin
						tick_q <= tick_q + 32'h00000001;
					end
				end
				default: begin
					state_q <= TX_IDLE;
					gate_q <= 1'b0;
				end
			endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign tx_data_o = shift_q[`WORD_W-1];
	assign tx_gate_o = gate_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_pulse_a: assert property (ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
	push_never_lost_a: assert property (fifo_in_valid |-> fifo_in_ready)
		else $error("word pushed into a full queue");
	parity_generated_a: assert property ( // R7
		(state_q == TX_IDLE) & fifo_out_valid & fifo_out_ready |=>
		shift_q[`PAR_W-1:0] == calc_parity(shift_q[`WORD_W-1:`PAR_W]))
		else $error("parity does not match info bits");
	voice_layout_a: assert property ( // R1
		fifo_in_valid & send_voice |-> fifo_in_data.info == voice_q)
		else $error("voice word fields misplaced");
	end_flag_a: assert property ( // R11
		fifo_in_valid & send_chal |->
		fifo_in_data.info[`CHAL_END_BIT] == wb_dat_i[`CTRL_LAST])
		else $error("end flag not taken from send command");
	bad_width_a: assert property ( // R14
		wb_fire & wr_voice & ~field_ok |=> voice_q == $past(voice_q) && width_err_q)
		else $error("bad width write not rejected");
	bad_type_a: assert property ( // R12
		wb_fire & wr_chal & field_ok & ~ohd_ok |=> chal_q == $past(chal_q) && type_err_q)
		else $error("bad overhead type not rejected");
	msb_first_out_a: assert property ( // R13
		(state_q == TX_IDLE) & fifo_out_valid & fifo_out_ready |=>
		tx_gate_o && tx_data_o == $past(fifo_out_data[`WORD_W-1]))
		else $error("first bit on air is not the msb");
	gate_min_span_a: assert property ($rose(tx_gate_o) |-> tx_gate_o[*8]) // R13
		else $error("word gate dropped early");
	stall_no_ack_a: assert property (wb_req & stall & ~ack_q |=> !ack_q)
		else $error("send acked while queue full");

	voice_sent_c: cover property (fifo_in_valid & send_voice);
	chal_sent_c: cover property (fifo_in_valid & send_chal & wb_dat_i[`CTRL_LAST]);
	queue_full_c: cover property (!fifo_in_ready);
	send_stalled_c: cover property (wb_req & stall);

endmodule

/* bench/mobile_rx_model.sv */
`timescale 1ns/10ps
// Receiver in place of the mobile; samples mid-bit so launch skew cannot flip a bit
module mobile_rx_model #(
	parameter int BIT_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tx_data_i,
	input wire logic tx_gate_i,
	input wire logic stall_i,
	output logic hold_o,
	output logic [39:0] word_o,
	output int word_cnt_o
);
	logic gate_q;
	logic [39:0] sh_q;
	int ph_q;
	int bit_q;
	int ph_d;
	// Slow answer: the bench holds the framer off
	assign hold_o = stall_i;
	assign ph_d = gate_q ? ((ph_q + 1) % BIT_CYCLES) : 0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_q <= 1'b0;
			ph_q <= 0;
			bit_q <= 0;
			sh_q <= 40'h0;
			word_o <= 40'h0;
			word_cnt_o <= 0;
		end else begin
			gate_q <= tx_gate_i;
			ph_q <= ph_d;
			if (!tx_gate_i) begin
				bit_q <= 0;
			end else if (ph_d == BIT_CYCLES / 2) begin
				sh_q <= {sh_q[38:0], tx_data_i};
				bit_q <= (bit_q == 39) ? 0 : bit_q + 1;
				if (bit_q == 39) begin
					word_o <= {sh_q[38:0], tx_data_i};
					word_cnt_o <= word_cnt_o + 1;
				end
			end
		end
	end
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
`include "framer_cfg.svh"
module testbench;
	import framer_pkg::*;
	localparam int BC = 4;
	logic clk_i, rst_i, cyc, stb, we, stall, hold, tx_data, tx_gate, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdq, rdat;
	logic [39:0] rx_word;
	logic [39:0] exp_q[$];
	logic [2:0] ohds [3] = '{3'b100, 3'b110, 3'b111};
	int rx_cnt, seen, fails, cmp_count;
	voice_channel_control_word_t v;
	first_random_challenge_word_t c, cw;

	voice_and_overhead_word_framer #(.BIT_CYCLES(BC), .FIFO_DEPTH(4)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdq), .wb_ack_o(ack), .tx_hold_i(hold),
		.tx_data_o(tx_data), .tx_gate_o(tx_gate));
	mobile_rx_model #(.BIT_CYCLES(BC)) rx (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(tx_data),
		.tx_gate_i(tx_gate), .stall_i(stall), .hold_o(hold), .word_o(rx_word),
		.word_cnt_o(rx_cnt));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	function automatic logic [39:0] frm(input logic [27:0] info);
		logic [11:0] r;
		r = 12'h000;
		for (int i = 27; i >= 0; i--) begin
			r = (r[11] ^ info[i]) ? ({r[10:0], 1'b0} ^ `PARITY_POLY) : {r[10:0], 1'b0};
		end
		return {info, r};
	endfunction

	task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request held until ack is seen at an edge; stb then low for a cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// No cycle count assumed: only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rdat = rdq;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(nm, {8'h00, e}, {8'h00, rdat});
	endtask

	task get_word(input string nm);
		while (rx_cnt == seen) begin
			@(posedge clk_i);
		end
		seen++;
		chk(nm, exp_q.pop_front(), rx_word);
	endtask

	task end_of_test;
		$display("Checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		end_of_test;
	end

	initial begin
		{cyc, stb, we, stall, rst_i} = 5'h01;
		adr = 8'h00;
		dat = 32'h0;
		sel = 4'h0;
		seen = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ADR_STATUS, 32'h0, "status reset");
		rd(8'h14, 32'h0, "unmapped read");
		rd(`ADR_VOICE, 32'h0, "voice reset");
		$display("Test reset done");
		v = '{2'b10, 2'b01, 2'b00, 8'h02, 3'b101, 11'h0d5};
		wr(`ADR_VOICE, {4'h0, v});
		rd(`ADR_VOICE, {4'h0, v}, "voice readback");
		exp_q.push_back(frm(v));
		wr(`ADR_CTRL, 32'h1);
		get_word("voice word");
		rd(`ADR_LAST, {20'h0, 12'(frm(v))}, "last parity");
		wr(`ADR_LAST, 32'hfff);
		rd(`ADR_LAST, {20'h0, 12'(frm(v))}, "parity kept");
		$display("Test voice done");
		// Hold the link so four words pile up and fill the queue
		stall <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			c = '{2'b11, 2'(k), 4'(k + 7), 16'ha5c0 + 16'(k), k == 0, ohds[k]};
			cw = c;
			wr(`ADR_CHAL, {4'h0, c});
			c.end_flag = (k == 2);
			exp_q.push_back(frm(c));
			wr(`ADR_CTRL, {29'h0, k == 2, 2'b10});
		end
		exp_q.push_back(frm(v));
		wr(`ADR_CTRL, 32'h1);
		rd(`ADR_STATUS, 32'h3, "queue full");
		// A send into the full queue must wait for room, then still land
		exp_q.push_back(frm(v));
		fork
			wr(`ADR_CTRL, 32'h1);
			begin
				repeat (20) @(posedge clk_i);
				stall <= 1'b0;
			end
		join
		repeat (5) get_word("train word");
		repeat (3 * BC) @(posedge clk_i);
		$display("Test train done");
		c.overhead_word_type = 3'b101;
		wr(`ADR_CHAL, {4'h0, c});
		rd(`ADR_STATUS, 32'h8, "type error");
		rd(`ADR_CHAL, {4'h0, cw}, "chal kept");
		wr(`ADR_STATUS, 32'hc);
		rd(`ADR_STATUS, 32'h0, "status clear");
		wr(`ADR_VOICE, {4'h1, v});
		rd(`ADR_STATUS, 32'h4, "wide value");
		wr(`ADR_STATUS, 32'hc);
		wb(1'b1, `ADR_VOICE, 32'h0, 4'h3);
		rd(`ADR_STATUS, 32'h4, "partial write");
		rd(`ADR_VOICE, {4'h0, v}, "voice kept");
		wr(`ADR_STATUS, 32'hc);
		wr(`ADR_CTRL, 32'h3);
		rd(`ADR_STATUS, 32'h8, "both sends");
		$display("Test refusal done");
		end_of_test;
	end
endmodule
